// >>> hw/board_ctrl_pkg.sv
// Shared constants for the board peripheral control register bank
package board_ctrl_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // ==========================================================
  // Printed register indices; the byte address is four times each
  localparam logic [31:0] SOFT_IRQ1_IDX = 32'hfffe102c;
  localparam logic [31:0] VECTOR_BASE_IDX = 32'hfffe102d;
  localparam logic [31:0] SOFT_IRQ2_IDX = 32'hfffe102e;
  localparam logic [31:0] REVISION_IDX = 32'hfffe102f;
  localparam logic [31:0] PRINTER_IDX = 32'hfffe2800;

  // Byte addresses seen on paddr
  localparam logic [ADDR_W-1:0] SOFT_IRQ1_ADDR = {SOFT_IRQ1_IDX[13:0], 2'b00};
  localparam logic [ADDR_W-1:0] VECTOR_BASE_ADDR = {VECTOR_BASE_IDX[13:0], 2'b00};
  localparam logic [ADDR_W-1:0] SOFT_IRQ2_ADDR = {SOFT_IRQ2_IDX[13:0], 2'b00};
  localparam logic [ADDR_W-1:0] REVISION_ADDR = {REVISION_IDX[13:0], 2'b00};
  localparam logic [ADDR_W-1:0] PRINTER_ADDR = {PRINTER_IDX[13:0], 2'b00};
  localparam logic [ADDR_W-1:0] GEN_CTRL_ADDR = 16'h0000;
  localparam logic [ADDR_W-1:0] EVT_STATUS_ADDR = 16'h0004;
  localparam logic [ADDR_W-1:0] EVT_CLEAR_ADDR = 16'h0008;
  localparam logic [ADDR_W-1:0] EVT_ENABLE_ADDR = 16'h000c;

  // ==========================================================
  // General control fields
  localparam int WAIT_BIT = 5;
  localparam int DMA_WIN_LO = 6;
  localparam int DMA_WIN_HI = 7;
  localparam int DMA_OFFSET_W = 24;

  // ==========================================================
  // Soft interrupt control fields
  localparam int LEVEL_LSB = 0;
  localparam int LEVEL_MSB = 2;
  localparam int ENABLE_BIT = 3;
  localparam int ACTIVE_BIT = 7;
  localparam logic [2:0] LEVEL_NONE = 3'h0;

  // ==========================================================
  // Vector base field
  localparam int VEC_LSB = 4;
  localparam int VEC_MSB = 7;

  // ==========================================================
  // Event bit positions
  localparam int EVT_W = 4;
  localparam int EVT_ACK = 0;
  localparam int EVT_FAULT = 1;
  localparam int EVT_READY = 2;
  localparam int EVT_SUPPLY = 3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] GEN_CTRL_RST = 8'h00;
  localparam logic [3:0] SOFT_CTRL_RST = 4'h0;
  localparam logic [3:0] VEC_RST = 4'h0;
  localparam logic [EVT_W-1:0] EVT_RST = 4'h0;

  // Locked sequence controller states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_ACQUIRE = 3'b010,
    SEQ_LOCKED = 3'b100
  } seq_state_t;

endpackage

// >>> hw/board_peripheral_control_regs.sv
// Peripheral control register bank with APB slave, soft interrupts and printer port
//
// Overview of operation
// - Wait bit set: gain bus before sequence
// - Wait bit clear: wait only if first access remote
// - Keep gained mastership until sequence ends
// - Two-bit field picks 16 MB DMA section
// - Three-bit level, zero means none, resets zero
// - Enable bit three, cleared by reset
// - Bit seven reads enable state, zero after reset
// - Vector nibble forms upper vector half
// - Read-only revision byte
// - Printer address: write data, read status
// - Status bits show printer conditions
// - Status bit one reads zero
// - Status bit zero shows fused supply
`timescale 1ns/10ps
module board_peripheral_control_regs
  import board_ctrl_pkg::*;
#(
  // Arbitrary revision value
  parameter logic [7:0] REVISION = 8'h01
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [board_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [board_ctrl_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [board_ctrl_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event interrupt
  output logic irq,
  // Printer port pins
  input wire logic printer_ack_pin,
  input wire logic printer_fault_pin,
  input wire logic printer_select_pin,
  input wire logic paper_out_pin,
  input wire logic printer_busy_pin,
  input wire logic supply_pin,
  output logic [7:0] printer_out_byte,
  output logic printer_strobe,
  // Locked sequence handshake
  input wire logic seq_request,
  input wire logic seq_first_sys,
  input wire logic seq_sys_access,
  input wire logic seq_done,
  output logic seq_proceed,
  input wire logic sysbus_grant_pin,
  output logic sysbus_request,
  // Soft interrupt requests
  output logic [2:0] irq_request_level,
  output logic [1:0] soft_irq_active,
  // Vector assembly
  input wire logic [3:0] iack_source_id,
  output logic [7:0] irq_vector,
  // Network DMA window
  input wire logic [board_ctrl_pkg::DMA_OFFSET_W-1:0] net_dma_offset,
  output logic [board_ctrl_pkg::DMA_OFFSET_W+1:0] net_dma_addr
);

  import board_ctrl_pkg::*;

  // ==========================================================
  // Declarations
  logic [5:0] pins_sync;
  logic sysbus_grant;
  logic paper_out_flag;
  logic printer_busy_flag;
  logic fused_supply_flag;
  logic ack_flag;
  logic fault_flag;
  logic select_flag;
  logic [5:0] pins_prev;
  logic [7:0] gen_ctrl;
  logic [3:0] soft1;
  logic [3:0] soft2;
  logic [3:0] vec_base;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_enable;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clear;
  logic [7:0] printer_condition;
  logic setup;
  logic wr_en;
  logic lane0;
  logic mapped;
  logic [DATA_W-1:0] next_rdata;
  logic [2:0] level1;
  logic [2:0] level2;
  logic locked_cycle_bus_wait;
  logic [1:0] net_dma_window;

  // ==========================================================
  // Pin synchronisers
  sync_stage #(
    .W(6)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({printer_ack_pin, printer_fault_pin, printer_select_pin,
               paper_out_pin, printer_busy_pin, supply_pin}),
    .sync_out(pins_sync)
  );

  sync_stage #(
    .W(1)
  ) u_grant_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(sysbus_grant_pin),
    .sync_out(sysbus_grant)
  );

  // Named views of synchronised pins
  assign ack_flag = pins_sync[5];
  assign fault_flag = pins_sync[4];
  assign select_flag = pins_sync[3];
  assign paper_out_flag = pins_sync[2];
  assign printer_busy_flag = pins_sync[1];
  assign fused_supply_flag = pins_sync[0];

  // ==========================================================
  // Printer status byte
  assign printer_condition = {ack_flag, fault_flag, select_flag,
                              paper_out_flag, printer_busy_flag,
                              1'b0,
                              1'b0,
                              fused_supply_flag};

  // ==========================================================
  // APB decode
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  assign lane0 = pstrb[0];

  // Address map membership
  always_comb begin
    mapped = 1'b0;
    case (paddr)
      GEN_CTRL_ADDR, EVT_STATUS_ADDR, EVT_CLEAR_ADDR, EVT_ENABLE_ADDR,
      SOFT_IRQ1_ADDR, VECTOR_BASE_ADDR, SOFT_IRQ2_ADDR, REVISION_ADDR,
      PRINTER_ADDR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Read data mux
  always_comb begin
    next_rdata = '0;
    case (paddr)
      GEN_CTRL_ADDR: next_rdata[7:0] = gen_ctrl;
      EVT_STATUS_ADDR: next_rdata[EVT_W-1:0] = evt_status;
      EVT_ENABLE_ADDR: next_rdata[EVT_W-1:0] = evt_enable;
      SOFT_IRQ1_ADDR: begin
        next_rdata[3:0] = soft1;
        next_rdata[ACTIVE_BIT] = soft1[ENABLE_BIT];
      end
      SOFT_IRQ2_ADDR: begin
        next_rdata[3:0] = soft2;
        next_rdata[ACTIVE_BIT] = soft2[ENABLE_BIT];
      end
      VECTOR_BASE_ADDR: next_rdata[VEC_MSB:VEC_LSB] = vec_base;
      REVISION_ADDR: next_rdata[7:0] = REVISION;
      PRINTER_ADDR: next_rdata[7:0] = printer_condition;
      default: next_rdata = '0;
    endcase
  end

  // Answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  // ==========================================================
  // General control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_ctrl <= GEN_CTRL_RST;
    end else if (wr_en && lane0 && paddr == GEN_CTRL_ADDR) begin
      gen_ctrl <= pwdata[7:0];
    end
  end

  assign locked_cycle_bus_wait = gen_ctrl[WAIT_BIT];
  assign net_dma_window = gen_ctrl[DMA_WIN_HI:DMA_WIN_LO];

  // DMA address lands in selected section
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      net_dma_addr <= '0;
    end else begin
      net_dma_addr <= {net_dma_window, net_dma_offset};
    end
  end

  // ==========================================================
  // Soft interrupt control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft1 <= SOFT_CTRL_RST;
    end else if (wr_en && lane0 && paddr == SOFT_IRQ1_ADDR) begin
      soft1 <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft2 <= SOFT_CTRL_RST;
    end else if (wr_en && lane0 && paddr == SOFT_IRQ2_ADDR) begin
      soft2 <= pwdata[3:0];
    end
  end

  // Effective levels; disabled or zero gives none
  assign level1 = soft1[ENABLE_BIT] ? soft1[LEVEL_MSB:LEVEL_LSB] : LEVEL_NONE;
  assign level2 = soft2[ENABLE_BIT] ? soft2[LEVEL_MSB:LEVEL_LSB] : LEVEL_NONE;

  // Request at the higher of the two levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request_level <= LEVEL_NONE;
      soft_irq_active <= 2'b00;
    end else begin
      irq_request_level <= (level1 > level2) ? level1 : level2;
      soft_irq_active <= {level2 != LEVEL_NONE, level1 != LEVEL_NONE};
    end
  end

  // ==========================================================
  // Vector base register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_base <= VEC_RST;
    end else if (wr_en && lane0 && paddr == VECTOR_BASE_ADDR) begin
      vec_base <= pwdata[VEC_MSB:VEC_LSB];
    end
  end

  // Vector: base nibble above source id
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_vector <= 8'h00;
    end else begin
      irq_vector <= {vec_base, iack_source_id};
    end
  end

  // ==========================================================
  // Printer output byte, kept across reset
  always_ff @(posedge pclk) begin
    if (wr_en && lane0 && paddr == PRINTER_ADDR) begin
      printer_out_byte <= pwdata[7:0];
    end
  end

  // One-cycle strobe per printer write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      printer_strobe <= 1'b0;
    end else begin
      printer_strobe <= wr_en && lane0 && paddr == PRINTER_ADDR;
    end
  end

  // ==========================================================
  // Event detection on printer and supply pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_prev <= 6'h00;
    end else begin
      pins_prev <= pins_sync;
    end
  end

  assign evt_set[EVT_ACK] = ack_flag && !pins_prev[5];
  assign evt_set[EVT_FAULT] = fault_flag && !pins_prev[4];
  assign evt_set[EVT_READY] = !printer_busy_flag && pins_prev[1];
  assign evt_set[EVT_SUPPLY] = !fused_supply_flag && pins_prev[0];

  // Write-one-to-clear strobe
  assign evt_clear = (wr_en && lane0 && paddr == EVT_CLEAR_ADDR) ?
                     pwdata[EVT_W-1:0] : '0;

  // Sticky status, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status <= EVT_RST;
    end else begin
      evt_status <= (evt_status & ~evt_clear) | evt_set;
    end
  end

  // Event enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_enable <= EVT_RST;
    end else if (wr_en && lane0 && paddr == EVT_ENABLE_ADDR) begin
      evt_enable <= pwdata[EVT_W-1:0];
    end
  end

  // Level interrupt from enabled status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((evt_status & ~evt_clear) | evt_set) & evt_enable);
    end
  end

  // ==========================================================
  // Locked sequence mastership control
  locked_seq_ctrl u_locked_seq (
    .pclk(pclk),
    .presetn(presetn),
    .locked_cycle_bus_wait(locked_cycle_bus_wait),
    .seq_request(seq_request),
    .seq_first_sys(seq_first_sys),
    .seq_sys_access(seq_sys_access),
    .seq_done(seq_done),
    .seq_proceed(seq_proceed),
    .sysbus_grant(sysbus_grant),
    .sysbus_request(sysbus_request)
  );

endmodule // board_peripheral_control_regs

// >>> hw/locked_seq_ctrl.sv
// System bus mastership control for locked multi-address sequences
`timescale 1ns/10ps
module locked_seq_ctrl
  import board_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Policy
  input wire logic locked_cycle_bus_wait,
  // Processor side
  input wire logic seq_request,
  input wire logic seq_first_sys,
  input wire logic seq_sys_access,
  input wire logic seq_done,
  output logic seq_proceed,
  // System bus side
  input wire logic sysbus_grant,
  output logic sysbus_request
);

  seq_state_t state;
  seq_state_t next_state;
  logic held;
  logic need_bus;

  // Bus needed before start
  assign need_bus = locked_cycle_bus_wait | seq_first_sys;

  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      SEQ_IDLE: begin
        if (seq_request) begin
          if (need_bus && !sysbus_grant) begin
            next_state = SEQ_ACQUIRE;
          end else begin
            next_state = SEQ_LOCKED;
          end
        end
      end
      SEQ_ACQUIRE: begin
        if (sysbus_grant) begin
          next_state = SEQ_LOCKED;
        end
      end
      SEQ_LOCKED: begin
        if (seq_done) begin
          next_state = SEQ_IDLE;
        end
      end
      default: next_state = SEQ_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SEQ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Mastership gained inside a sequence is kept to its end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= 1'b0;
    end else if (next_state == SEQ_IDLE) begin
      held <= 1'b0;
    end else if (sysbus_grant && state != SEQ_IDLE) begin
      held <= 1'b1;
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysbus_request <= 1'b0;
      seq_proceed <= 1'b0;
    end else begin
      sysbus_request <= (next_state == SEQ_ACQUIRE) ||
                        (next_state == SEQ_LOCKED && (held || sysbus_grant || seq_sys_access));
      seq_proceed <= (next_state == SEQ_LOCKED);
    end
  end

endmodule // locked_seq_ctrl

// >>> hw/sync_stage.sv
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/10ps
module sync_stage #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // sync_stage

// >>> testbench/board_peripheral_control_regs_tb_top.sv
// Self-checking bench for the register bank
`timescale 1ns/10ps
module board_peripheral_control_regs_tb_top;
  import board_ctrl_pkg::*;
  typedef struct {logic [31:0] v; logic [31:0] m; logic e;} exp_t;
  // Arbitrary revision value
  localparam logic [7:0] REV = 8'h3c;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rnd = 32'he8274053;
  logic pready, pslverr, irq, strobe, sreq = 0, sfirst = 0, sacc = 0, sdone = 0, proceed;
  logic grant, ack, fault, sel, paper, busy, sup, sysreq;
  logic [7:0] pbyte, vec;
  logic [3:0] cond = 0, iack = 0;
  logic [1:0] lag = 0, act;
  logic [2:0] lvl;
  logic [23:0] off = 0;
  logic [25:0] daddr;
  exp_t q[$];
  int err_total = 0, checks = 0;

  board_peripheral_control_regs #(.REVISION(REV)) board_peripheral_control_regs_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .printer_ack_pin(ack), .printer_fault_pin(fault),
    .printer_select_pin(sel), .paper_out_pin(paper), .printer_busy_pin(busy),
    .supply_pin(sup), .printer_out_byte(pbyte), .printer_strobe(strobe),
    .seq_request(sreq), .seq_first_sys(sfirst), .seq_sys_access(sacc), .seq_done(sdone),
    .seq_proceed(proceed), .sysbus_grant_pin(grant), .sysbus_request(sysreq),
    .irq_request_level(lvl), .soft_irq_active(act), .iack_source_id(iack),
    .irq_vector(vec), .net_dma_offset(off), .net_dma_addr(daddr));
  far_side_model far_side_model_i (.pclk(pclk), .cond(cond), .lag(lag),
    .sysbus_request(sysreq), .printer_strobe(strobe), .sysbus_grant_pin(grant),
    .printer_ack_pin(ack), .printer_fault_pin(fault), .printer_select_pin(sel),
    .paper_out_pin(paper), .printer_busy_pin(busy), .supply_pin(sup));

  // ==========================================
  // Clock and helpers
  initial begin
    forever #20 pclk = ~pclk;
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [2:0] eff(input logic [3:0] c);
    return c[3] ? c[2:0] : 3'h0;
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // ==========================================
  // APB master; reads note their expectation
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : nx(rnd);
    if (!w) q.push_back('{d & m, m, e});
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    if (n == 20) chk("pready", 1, 0);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1, a, d, 0, 0);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] v, input logic [31:0] m);
    apb(0, a, v, m, 0);
  endtask
  // Read result monitor
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("prdata", q[0].v, prdata & q[0].m);
      chk("pslverr", q[0].e, pslverr);
      void'(q.pop_front());
    end
  end

  // ==========================================
  // Locked sequence with bus wait policy ws and first target fs
  task automatic sq(input logic ws, input logic fs);
    int n;
    wr(GEN_CTRL_ADDR, {26'h0, ws, 5'h0});
    sreq <= 1;
    sfirst <= fs;
    lag <= {ws, fs};
    for (n = 0; n < 40 && proceed !== 1'b1; n++) @(posedge pclk);
    if (n == 40) chk("seq_wait", 1, 0);
    chk("grant", ws | fs, grant);
    sreq <= 0;
    sacc <= 1;
    tick(3);
    sacc <= 0;
    tick(3);
    chk("sysreq", 1, sysreq);
    sdone <= 1;
    tick(1);
    sdone <= 0;
    tick(2);
    chk("proceed", 0, {proceed, sysreq});
  endtask

  // Watchdog
  initial begin
    #400000;
    err_total++;
    end_sim();
  end

  // ==========================================
  // Main sequence
  initial begin
    logic [3:0] v;
    logic [7:0] s;
    tick(2);
    presetn <= 1;
    rd(SOFT_IRQ1_ADDR, 0, 32'h8f);
    rd(VECTOR_BASE_ADDR, 0, 32'hf0);
    rd(REVISION_ADDR, REV, 32'hff);
    apb(0, 16'h0100, 0, 32'hffffffff, 1);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      v = i;
      rnd = nx(rnd);
      wr(SOFT_IRQ1_ADDR, v);
      wr(SOFT_IRQ2_ADDR, rnd[3:0]);
      rd(SOFT_IRQ1_ADDR, {v[3], 3'h0, v}, 32'h8f);
      rd(SOFT_IRQ2_ADDR, {rnd[3], 3'h0, rnd[3:0]}, 32'h8f);
      s = (eff(v) > eff(rnd[3:0])) ? eff(v) : eff(rnd[3:0]);
      chk("level", s, lvl);
      chk("active", {eff(rnd[3:0]) != 0, eff(v) != 0}, act);
    end
    $display("test soft_irq done");
    for (int w = 0; w < 4; w++) begin
      rnd = nx(rnd);
      wr(GEN_CTRL_ADDR, w << 6);
      wr(VECTOR_BASE_ADDR, rnd[7:0]);
      off <= rnd[31:8];
      iack <= rnd[3:0];
      tick(2);
      chk("dma", {w[1:0], rnd[31:8]}, daddr);
      chk("vector", {rnd[7:4], rnd[3:0]}, vec);
    end
    $display("test window done");
    for (int i = 0; i < 4; i++) begin
      rnd = nx(rnd);
      cond <= rnd[3:0];
      tick(4);
      rd(PRINTER_ADDR, {1'b0, rnd[3:1], 3'h0, rnd[0]}, 32'hff);
    end
    wr(EVT_ENABLE_ADDR, 0);
    wr(PRINTER_ADDR, 32'h5a);
    tick(1);
    chk("pbyte", 8'h5a, pbyte);
    // Status captured while the synced busy level is high
    tick(2);
    rd(PRINTER_ADDR, {1'b0, rnd[3:1], 1'b1, 2'h0, rnd[0]}, 32'hff);
    tick(12);
    chk("irq_masked", 0, irq);
    rd(EVT_STATUS_ADDR, 5, 32'h5);
    wr(EVT_ENABLE_ADDR, 1);
    tick(2);
    chk("irq", 1, irq);
    wr(EVT_CLEAR_ADDR, 5);
    tick(2);
    chk("irq_clear", 0, irq);
    $display("test printer done");
    for (int i = 0; i < 4; i++) sq(i[1], i[0]);
    $display("test locked done");
    wr(SOFT_IRQ1_ADDR, 8'hf);
    presetn <= 0;
    tick(2);
    presetn <= 1;
    chk("pbyte_kept", 8'h5a, pbyte);
    rd(SOFT_IRQ1_ADDR, 0, 32'h8f);
    $display("test rereset done");
    end_sim();
  end
endmodule // board_peripheral_control_regs_tb_top

// >>> testbench/board_regs_checker.sv
// Port-level assertions for the register bank
`timescale 1ns/10ps
module board_regs_checker
  import board_ctrl_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h01
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [board_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [board_ctrl_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [board_ctrl_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Printer and sequence
  input wire logic [7:0] printer_out_byte,
  input wire logic printer_strobe,
  input wire logic seq_first_sys,
  input wire logic seq_done,
  input wire logic seq_proceed,
  input wire logic sysbus_request,
  // Interrupt, vector and window
  input wire logic [2:0] irq_request_level,
  input wire logic [1:0] soft_irq_active,
  input wire logic [3:0] iack_source_id,
  input wire logic [7:0] irq_vector,
  input wire logic [board_ctrl_pkg::DMA_OFFSET_W-1:0] net_dma_offset,
  input wire logic [board_ctrl_pkg::DMA_OFFSET_W+1:0] net_dma_addr
);
  // ==========================================
  // Access edge of a transfer
  logic acc;
  logic rd;
  assign acc = psel && penable && pready;
  assign rd = acc && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================
  // Relations
  a_pready_one: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single pulse");
  a_err_resp: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_print_write: assert property (acc && pwrite && pstrb[0] && paddr == PRINTER_ADDR
    |=> printer_strobe && printer_out_byte == $past(pwdata[7:0]))
    else $error("printer byte not driven");
  a_print_low: assert property (rd && paddr == PRINTER_ADDR |-> !prdata[1])
    else $error("status bit one set");
  a_rev_read: assert property (rd && paddr == REVISION_ADDR |-> prdata[7:0] == REVISION)
    else $error("revision mismatch");
  a_stat_enable: assert property (rd && (paddr == SOFT_IRQ1_ADDR ||
    paddr == SOFT_IRQ2_ADDR) |-> prdata[7] == prdata[3]) else $error("bit seven wrong");
  a_dma_offset: assert property (presetn |=> net_dma_addr[23:0] == $past(net_dma_offset))
    else $error("dma offset lost");
  a_vector_low: assert property (presetn |=> irq_vector[3:0] == $past(iack_source_id))
    else $error("vector low nibble wrong");
  a_level_active: assert property ((irq_request_level != 3'h0) ==
    (soft_irq_active != 2'b00)) else $error("level and active disagree");
  a_first_sys: assert property ($rose(seq_proceed) && seq_first_sys |-> sysbus_request)
    else $error("proceed without bus");
  a_mastership_kept: assert property (seq_proceed && sysbus_request && !seq_done
    |=> sysbus_request) else $error("mastership dropped");
endmodule // board_regs_checker

bind board_peripheral_control_regs board_regs_checker #(.REVISION(REVISION)) chk_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .printer_out_byte(printer_out_byte), .printer_strobe(printer_strobe),
  .seq_first_sys(seq_first_sys), .seq_done(seq_done), .seq_proceed(seq_proceed),
  .sysbus_request(sysbus_request), .irq_request_level(irq_request_level),
  .soft_irq_active(soft_irq_active), .iack_source_id(iack_source_id),
  .irq_vector(irq_vector), .net_dma_offset(net_dma_offset), .net_dma_addr(net_dma_addr));

// >>> testbench/far_side_model.sv
// Printer and system bus arbiter seen from the block
`timescale 1ns/10ps
module far_side_model (
  // Clock
  input wire logic pclk,
  // Controls from the bench
  input wire logic [3:0] cond,
  input wire logic [1:0] lag,
  // From the block
  input wire logic sysbus_request,
  input wire logic printer_strobe,
  // To the block
  output logic sysbus_grant_pin,
  output logic printer_ack_pin,
  output logic printer_fault_pin,
  output logic printer_select_pin,
  output logic paper_out_pin,
  output logic printer_busy_pin,
  output logic supply_pin
);
  int gc = 0;
  int pc = 0;
  // Grant after lag cycles, busy then acknowledge after each strobe
  always @(posedge pclk) begin
    gc <= sysbus_request ? gc + 1 : 0;
    pc <= printer_strobe ? 1 : ((pc != 0 && pc < 7) ? pc + 1 : 0);
  end
  // Pin levels
  assign sysbus_grant_pin = sysbus_request && (gc >= lag);
  assign printer_busy_pin = pc inside {[1:4]};
  assign printer_ack_pin = pc inside {[5:6]};
  assign {printer_fault_pin, printer_select_pin, paper_out_pin, supply_pin} = cond;
endmodule // far_side_model
